// ### hw/mssx_pkg.sv
// Shared constants and types of the swap, skip, table read and xor unit.
package mssx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned MSSX_DATA_W = 8;
  localparam int unsigned MSSX_WORD_W = 14;
  localparam int unsigned MSSX_HIGH_W = MSSX_WORD_W - MSSX_DATA_W;
  localparam int unsigned MSSX_PROG_ADDR_W = 11;
  localparam int unsigned MSSX_PTR_W = 8;
  localparam int unsigned MSSX_PAGE_W = MSSX_PROG_ADDR_W - MSSX_PTR_W;
  localparam int unsigned MSSX_NIBBLE_W = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] MSSX_ACC_RESET = 8'h00;
  localparam logic MSSX_ZERO_RESET = 1'b0;
  localparam logic [5:0] MSSX_HIGH_RESET = 6'h00;
  localparam logic [10:0] MSSX_ADDR_RESET = 11'h000;
  localparam logic [7:0] MSSX_BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Cycle counts of the instructions
  // ----------------------------------------------------------------
  localparam int unsigned MSSX_PLAIN_CYCLES = 1;
  localparam int unsigned MSSX_SKIP_CYCLES = 2;
  localparam int unsigned MSSX_TABLE_CYCLES = 2;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_idle,
    op_nibble_swap_to_accumulator,
    op_skip_on_zero,
    op_move_and_skip_on_zero,
    op_skip_on_bit_zero,
    op_table_read_current_page,
    op_table_read_last_page,
    op_xor_to_accumulator,
    op_exclusive_or_to_memory,
    op_xor_immediate
  } mssx_op_type;

  typedef enum logic [1:0] {
    st_ready,
    st_dummy,
    st_fetch
  } mssx_state_type;

endpackage

// ### hw/mssx_alu.sv
// Combinational result, flag and skip logic for one instruction.
module mssx_alu
  import mssx_pkg::*;
(
  input wire mssx_op_type op_code,     // Operation to evaluate.
  input wire logic [7:0] accumulator,  // Present accumulator.
  input wire logic [7:0] mem_data,     // Addressed data byte.
  input wire logic [2:0] bit_sel,      // Bit index for the bit test.
  input wire logic [7:0] imm,          // Immediate operand.
  output logic [7:0] next_acc,         // Accumulator result.
  output logic acc_we,                 // Accumulator is written.
  output logic [7:0] next_mem,         // Data byte result.
  output logic mem_we,                 // Data byte is written.
  output logic next_zero,              // Zero flag result.
  output logic zero_we,                // Zero flag is written.
  output logic skip,                   // Next instruction is skipped.
  output logic table_req,              // Table read is requested.
  output logic last_page               // Table read uses the last page.
);

  logic [7:0] xor_val;

  always_comb begin
    next_acc = accumulator;
    acc_we = 1'b0;
    next_mem = mem_data;
    mem_we = 1'b0;
    xor_val = MSSX_BYTE_ZERO;
    zero_we = 1'b0;
    skip = 1'b0;
    table_req = 1'b0;
    last_page = 1'b0;
    unique case (op_code)
      op_idle: begin
      end
      op_nibble_swap_to_accumulator: begin
        // see RQ1
        next_acc = {mem_data[3:0], mem_data[7:4]};
        acc_we = 1'b1;
      end
      op_skip_on_zero: begin
        skip = (mem_data == MSSX_BYTE_ZERO); // see RQ2
      end
      op_move_and_skip_on_zero: begin
        // see RQ3
        next_acc = mem_data;
        acc_we = 1'b1;
        skip = (mem_data == MSSX_BYTE_ZERO);
      end
      op_skip_on_bit_zero: begin
        skip = ~mem_data[bit_sel]; // see RQ4
      end
      op_table_read_current_page: begin
        table_req = 1'b1; // see RQ6
      end
      op_table_read_last_page: begin
        table_req = 1'b1;
        last_page = 1'b1; // see RQ7
      end
      op_xor_to_accumulator: begin
        xor_val = accumulator ^ mem_data; // see RQ8
        next_acc = xor_val;
        acc_we = 1'b1;
        zero_we = 1'b1;
      end
      op_exclusive_or_to_memory: begin
        xor_val = accumulator ^ mem_data; // see RQ9
        next_mem = xor_val;
        mem_we = 1'b1;
        zero_we = 1'b1;
      end
      op_xor_immediate: begin
        xor_val = accumulator ^ imm; // see RQ10
        next_acc = xor_val;
        acc_we = 1'b1;
        zero_we = 1'b1;
      end
      default: begin
      end
    endcase
    next_zero = (xor_val == MSSX_BYTE_ZERO); // see RQ11
  end

endmodule

// ### hw/mssx_exec.sv
// Execution unit for nibble swap, zero skips, table reads and xor forms.
//
// Contract
// RQ1 - Swap puts byte high nibble in accumulator low, low nibble high.
// RQ2 - Skip on zero byte skips next instruction in 2 cycles, else 1.
// RQ3 - Move and skip copies byte to accumulator, skips when it is zero.
// RQ4 - Bit test skips in 2 cycles when selected bit is 0, else 1.
// RQ5 - A skip discards the prefetched instruction and inserts one dummy.
// RQ6 - Current page table read: low byte to memory, high to table high.
// RQ7 - Last page table read addresses the last program page instead.
// RQ8 - Xor with byte stores into accumulator, changes only zero flag.
// RQ9 - Xor to memory writes the byte back, changes only zero flag.
// RQ10 - Immediate xor stores into accumulator, changes only zero flag.
// RQ11 - Zero flag is set when the xor result is zero, else cleared.
module mssx_exec
  import mssx_pkg::*;
#(
  parameter int unsigned PAGE_W = MSSX_PAGE_W,  // Program page bits.
  parameter int unsigned PTR_W = MSSX_PTR_W     // Table pointer bits.
)
(
  input wire logic clock,                        // System clock.
  input wire logic rst_b,                        // Synchronous reset.
  input wire logic op_valid,                     // Instruction offered.
  input wire mssx_op_type op_code,               // Instruction to run.
  input wire logic [7:0] mem_data,               // Addressed data byte.
  input wire logic [2:0] bit_sel,                // Bit index for test.
  input wire logic [7:0] imm,                    // Immediate operand.
  input wire logic [PAGE_W-1:0] pc_page,         // Current program page.
  input wire logic [PTR_W-1:0] table_pointer,    // Table pointer value.
  input wire logic [13:0] prog_word,             // Program memory word.
  output logic op_ready,                         // Next op is accepted.
  output logic [7:0] accumulator,                // Accumulator.
  output logic zero_flag,                        // Zero status flag.
  output logic [5:0] table_high_register,        // Table high part.
  output logic mem_wr,                           // Data byte write.
  output logic [7:0] mem_wr_data,                // Data byte to write.
  output logic discard_fetch,                    // Drop prefetched op.
  output logic dummy_cycle,                      // Dummy cycle running.
  output logic prog_rd,                          // Program memory read.
  output logic [PAGE_W+PTR_W-1:0] prog_addr,     // Program word address.
  output logic op_done                           // Instruction finished.
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic take;
  logic [7:0] alu_acc;
  logic alu_acc_we;
  logic [7:0] alu_mem;
  logic alu_mem_we;
  logic alu_zero;
  logic alu_zero_we;
  logic alu_skip;
  logic alu_table;
  logic alu_last;
  mssx_state_type state;
  mssx_state_type next_state;

  // Offers while busy or with no operation are ignored.
  assign take = op_valid && op_ready && (op_code != op_idle);

  mssx_alu u_alu (
    .op_code(op_code),
    .accumulator(accumulator),
    .mem_data(mem_data),
    .bit_sel(bit_sel),
    .imm(imm),
    .next_acc(alu_acc),
    .acc_we(alu_acc_we),
    .next_mem(alu_mem),
    .mem_we(alu_mem_we),
    .next_zero(alu_zero),
    .zero_we(alu_zero_we),
    .skip(alu_skip),
    .table_req(alu_table),
    .last_page(alu_last)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      st_ready: begin
        if (take && alu_skip) begin
          next_state = st_dummy; // see RQ5
        end else if (take && alu_table) begin
          next_state = st_fetch;
        end
      end
      st_dummy: begin
        next_state = st_ready;
      end
      st_fetch: begin
        next_state = st_ready;
      end
      default: begin
        next_state = st_ready;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= st_ready;
      op_ready <= 1'b0;
    end else begin
      state <= next_state;
      op_ready <= (next_state == st_ready);
    end
  end

  // ----------------------------------------------------------------
  // Skip handling
  // ----------------------------------------------------------------
  // The prefetched instruction is dropped at once and the slot it held
  // becomes one dummy cycle, so a taken skip lasts two cycles.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      discard_fetch <= 1'b0;
      dummy_cycle <= 1'b0;
    end else begin
      discard_fetch <= take && alu_skip; // see RQ5
      dummy_cycle <= (next_state == st_dummy); // see RQ2 see RQ4
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and zero flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      accumulator <= MSSX_ACC_RESET;
    end else if (take && alu_acc_we) begin
      accumulator <= alu_acc; // see RQ1 see RQ3 see RQ8 see RQ10
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      zero_flag <= MSSX_ZERO_RESET;
    end else if (take && alu_zero_we) begin
      zero_flag <= alu_zero; // see RQ11
    end
  end

  // ----------------------------------------------------------------
  // Table read
  // ----------------------------------------------------------------
  // The word is read in the cycle after the request, so a table read
  // holds the unit for one extra cycle.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prog_rd <= 1'b0;
      prog_addr <= MSSX_ADDR_RESET[PAGE_W+PTR_W-1:0];
    end else if (take && alu_table) begin
      prog_rd <= 1'b1;
      if (alu_last) begin
        prog_addr <= {{PAGE_W{1'b1}}, table_pointer}; // see RQ7
      end else begin
        prog_addr <= {pc_page, table_pointer}; // see RQ6
      end
    end else begin
      prog_rd <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      table_high_register <= MSSX_HIGH_RESET;
    end else if (state == st_fetch) begin
      table_high_register <= prog_word[13:8]; // see RQ6
    end
  end

  // ----------------------------------------------------------------
  // Data memory write and completion
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mem_wr <= 1'b0;
      mem_wr_data <= MSSX_BYTE_ZERO;
    end else if (state == st_fetch) begin
      mem_wr <= 1'b1;
      mem_wr_data <= prog_word[7:0]; // see RQ6 see RQ7
    end else if (take && alu_mem_we) begin
      mem_wr <= 1'b1;
      mem_wr_data <= alu_mem; // see RQ9
    end else begin
      mem_wr <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_done <= 1'b0;
    end else begin
      op_done <= (take && !alu_skip && !alu_table) ||
                 (state != st_ready);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_take_of(mssx_op_type o);
    op_valid && op_ready && (op_code == o);
  endsequence

  sequence s_dummy_slot;
    discard_fetch && dummy_cycle && !op_ready && !op_done;
  endsequence

  sequence s_end_after_dummy;
    op_done && op_ready && !discard_fetch && !dummy_cycle;
  endsequence

  sequence s_table_store;
    mem_wr && op_done && op_ready &&
      mem_wr_data == $past(prog_word[7:0]) &&
      table_high_register == $past(prog_word[13:8]);
  endsequence

  property p_swap;
    s_take_of(op_nibble_swap_to_accumulator) |=>
      accumulator == {$past(mem_data[3:0]), $past(mem_data[7:4])} &&
      zero_flag == $past(zero_flag) && !mem_wr;
  endproperty
  a_swap: assert property (p_swap) // see RQ1
    else $error("nibble swap result wrong");

  property p_skip_two;
    op_valid && op_ready && alu_skip |=>
      s_dummy_slot ##1 s_end_after_dummy;
  endproperty
  a_skip_two: assert property (p_skip_two) // see RQ5
    else $error("skip did not take two cycles");

  // A busy cycle must leave the accumulator and zero flag alone and start no program read or discard.
  property p_busy_refuse;
    !op_ready |=>
      accumulator == $past(accumulator) &&
      zero_flag == $past(zero_flag) && !prog_rd && !discard_fetch;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) // see RQ5
    else $error("offer taken while busy");

  property p_zero_skip;
    s_take_of(op_skip_on_zero) |=>
      discard_fetch == ($past(mem_data) == 8'h00) &&
      zero_flag == $past(zero_flag) &&
      op_done == ($past(mem_data) != 8'h00);
  endproperty
  a_zero_skip: assert property (p_zero_skip) // see RQ2
    else $error("zero byte skip wrong");

  property p_move_skip;
    s_take_of(op_move_and_skip_on_zero) |=>
      accumulator == $past(mem_data) &&
      discard_fetch == ($past(mem_data) == 8'h00) &&
      zero_flag == $past(zero_flag);
  endproperty
  a_move_skip: assert property (p_move_skip) // see RQ3
    else $error("move and skip wrong");

  property p_bit_skip;
    s_take_of(op_skip_on_bit_zero) |=>
      discard_fetch == !$past(mem_data[bit_sel]) &&
      accumulator == $past(accumulator);
  endproperty
  a_bit_skip: assert property (p_bit_skip) // see RQ4
    else $error("bit test skip wrong");

  property p_table_current;
    s_take_of(op_table_read_current_page) |=>
      prog_rd && !op_ready &&
      prog_addr == {$past(pc_page), $past(table_pointer)} ##1
      s_table_store;
  endproperty
  a_table_current: assert property (p_table_current) // see RQ6
    else $error("current page table read wrong");

  property p_table_last;
    s_take_of(op_table_read_last_page) |=>
      prog_rd && !op_ready &&
      prog_addr == {{PAGE_W{1'b1}}, $past(table_pointer)} ##1
      s_table_store;
  endproperty
  a_table_last: assert property (p_table_last) // see RQ7
    else $error("last page table read wrong");

  property p_xor_acc;
    s_take_of(op_xor_to_accumulator) |=>
      accumulator == ($past(accumulator) ^ $past(mem_data)) &&
      zero_flag == (accumulator == 8'h00) && !mem_wr;
  endproperty
  a_xor_acc: assert property (p_xor_acc) // see RQ8 see RQ11
    else $error("xor into accumulator wrong");

  property p_xor_mem;
    s_take_of(op_exclusive_or_to_memory) |=>
      mem_wr && mem_wr_data == ($past(accumulator) ^ $past(mem_data)) &&
      accumulator == $past(accumulator) &&
      zero_flag == (mem_wr_data == 8'h00);
  endproperty
  a_xor_mem: assert property (p_xor_mem) // see RQ9 see RQ11
    else $error("xor to memory wrong");

  property p_xor_imm;
    s_take_of(op_xor_immediate) |=>
      accumulator == ($past(accumulator) ^ $past(imm)) &&
      zero_flag == (accumulator == 8'h00);
  endproperty
  a_xor_imm: assert property (p_xor_imm) // see RQ10 see RQ11
    else $error("immediate xor wrong");

endmodule

// ### bench/mssx_exec_tb.sv
// Self-checking testbench of the swap, skip, table read and xor unit.
module mssx_exec_tb
  import mssx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock, rst_b, op_valid;
  mssx_op_type op_code;
  logic [7:0] mem_data, imm, table_pointer, accumulator, mem_wr_data;
  logic [7:0] acc_exp;
  logic [2:0] bit_sel, pc_page;
  logic [13:0] prog_word;
  logic [10:0] prog_addr;
  logic [5:0] table_high_register;
  logic op_ready, zero_flag, mem_wr, discard_fetch, dummy_cycle;
  logic prog_rd, op_done, z_exp;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  mssx_exec dut (
    .clock(clock), .rst_b(rst_b), .op_valid(op_valid),
    .op_code(op_code), .mem_data(mem_data), .bit_sel(bit_sel),
    .imm(imm), .pc_page(pc_page), .table_pointer(table_pointer),
    .prog_word(prog_word), .op_ready(op_ready),
    .accumulator(accumulator), .zero_flag(zero_flag),
    .table_high_register(table_high_register), .mem_wr(mem_wr),
    .mem_wr_data(mem_wr_data), .discard_fetch(discard_fetch),
    .dummy_cycle(dummy_cycle), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .op_done(op_done)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [13:0] seen, input logic [13:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  // Offers one instruction and returns at the falling edge after its take.
  task automatic offer(input mssx_op_type op, input logic [7:0] mem,
                       input logic [2:0] bs, input logic [7:0] im);
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check(14'(op_ready), 14'h0001, "ready before offer");
    op_valid = 1'b1;
    op_code = op;
    mem_data = mem;
    bit_sel = bs;
    imm = im;
    @(negedge clock);
  endtask

  task automatic quiet();
    op_valid = 1'b0;
    op_code = op_idle;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_xor_chain();
    offer(op_move_and_skip_on_zero, 8'h5A, 3'h0, 8'h00);
    acc_exp = 8'h5A;
    check(14'(accumulator), 14'(acc_exp), "move no skip acc");
    check(14'(op_done), 14'h0001, "move no skip done");
    offer(op_xor_to_accumulator, 8'h5A, 3'h0, 8'h00);
    acc_exp = 8'h00;
    z_exp = 1'b1;
    check(14'(accumulator), 14'(acc_exp), "xor acc");
    check(14'(zero_flag), 14'(z_exp), "xor zero set");
    check(14'(mem_wr), 14'h0000, "xor acc no write");
    offer(op_xor_immediate, 8'hFF, 3'h0, 8'h3C);
    acc_exp = 8'h3C;
    z_exp = 1'b0;
    check(14'(accumulator), 14'(acc_exp), "xor imm acc");
    check(14'(zero_flag), 14'(z_exp), "xor imm zero clear");
    offer(op_exclusive_or_to_memory, 8'h3C, 3'h0, 8'h00);
    check(14'(mem_wr), 14'h0001, "exclusive_or_to_memory write");
    check(14'(mem_wr_data), 14'h0000, "exclusive_or_to_memory data");
    check(14'(zero_flag), 14'h0001, "exclusive_or_to_memory zero set");
    check(14'(accumulator), 14'(acc_exp), "exclusive_or_to_memory acc kept");
    offer(op_exclusive_or_to_memory, 8'h0F, 3'h0, 8'h00);
    quiet();
    z_exp = 1'b0;
    check(14'(mem_wr_data), 14'h0033, "exclusive_or_to_memory data 2");
    check(14'(zero_flag), 14'(z_exp), "exclusive_or_to_memory zero clear");
    @(negedge clock);
    check(14'(mem_wr), 14'h0000, "write pulse ends");
  endtask

  task automatic skip_case(input mssx_op_type op, input logic [7:0] mem,
                           input logic [2:0] bs, input logic taken);
    offer(op, mem, bs, 8'h00);
    quiet();
    if (op == op_move_and_skip_on_zero) begin
      acc_exp = mem;
    end
    check(14'(discard_fetch), 14'(taken), "discard");
    check(14'(dummy_cycle), 14'(taken), "dummy");
    check(14'(op_done), 14'(!taken), "done after one");
    check(14'(op_ready), 14'(!taken), "ready in skip");
    check(14'(accumulator), 14'(acc_exp), "skip acc");
    check(14'(zero_flag), 14'(z_exp), "skip flag kept");
    @(negedge clock);
    check(14'(op_done), 14'(taken), "done after two");
    check(14'(dummy_cycle), 14'h0000, "single dummy");
    check(14'(op_ready), 14'h0001, "ready after skip");
  endtask

  task automatic t_swap(input logic [7:0] mem, input logic [7:0] res);
    offer(op_nibble_swap_to_accumulator, mem, 3'h0, 8'h00);
    quiet();
    acc_exp = res;
    check(14'(accumulator), 14'(acc_exp), "swap acc");
    check(14'(zero_flag), 14'(z_exp), "swap flag kept");
    check(14'(mem_wr), 14'h0000, "swap no write");
  endtask

  task automatic t_table(input mssx_op_type op, input logic [2:0] pg,
                         input logic [7:0] ptr, input logic [13:0] word,
                         input logic [10:0] addr);
    pc_page = pg;
    table_pointer = ptr;
    // The offer stands through the busy cycle and must be refused.
    offer(op, 8'h00, 3'h0, 8'h00);
    check(14'(prog_rd), 14'h0001, "table read strobe");
    check(14'(prog_addr), 14'(addr), "table addr");
    check(14'(op_ready), 14'h0000, "table busy");
    prog_word = word;
    @(negedge clock);
    prog_word = ~word;
    pc_page = ~pg;
    quiet();
    check(14'(prog_rd), 14'h0000, "busy offer refused");
    check(14'(mem_wr), 14'h0001, "table write");
    check(14'(mem_wr_data), 14'(word[7:0]), "table low");
    check(14'(table_high_register), 14'(word[13:8]),
          "table high");
    check(14'(op_done), 14'h0001, "table done");
    check(14'(zero_flag), 14'(z_exp), "table flag kept");
    check(14'(accumulator), 14'(acc_exp), "table acc kept");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = op_idle;
    mem_data = 8'h00;
    bit_sel = 3'h0;
    imm = 8'h00;
    pc_page = 3'h0;
    table_pointer = 8'h00;
    prog_word = 14'h0000;
    repeat (12) @(negedge clock);
    check(14'(accumulator), 14'h0000, "reset acc");
    check(14'(zero_flag), 14'h0000, "reset zero");
    check(14'(table_high_register), 14'h0000, "reset table high");
    check(14'(op_ready), 14'h0000, "reset ready");
    rst_b = 1'b1;
    z_exp = 1'b0;
    t_xor_chain();
    // Set the zero flag so that the later flag-kept checks can trip.
    offer(op_xor_immediate, 8'h00, 3'h0, 8'h3C);
    check(14'(zero_flag), 14'h0001, "xor imm zero set");
    z_exp = 1'b1;
    acc_exp = 8'h00;
    skip_case(op_skip_on_zero, 8'h00, 3'h0, 1'b1);
    skip_case(op_skip_on_zero, 8'h80, 3'h0, 1'b0);
    skip_case(op_skip_on_bit_zero, 8'hF7, 3'h3, 1'b1);
    skip_case(op_skip_on_bit_zero, 8'h80, 3'h7, 1'b0);
    skip_case(op_skip_on_bit_zero, 8'h7F, 3'h7, 1'b1);
    skip_case(op_move_and_skip_on_zero, 8'h00, 3'h0, 1'b1);
    skip_case(op_move_and_skip_on_zero, 8'h01, 3'h0, 1'b0);
    t_swap(8'hA5, 8'h5A);
    t_swap(8'h0F, 8'hF0);
    t_table(op_table_read_current_page, 3'h5, 8'hC4, 14'h2A7E, 11'h5C4);
    t_table(op_table_read_last_page, 3'h2, 8'h01, 14'h3F00, 11'h701);
    @(negedge clock);
    conclude();
  end
endmodule
